/* cell_pkg.sv */
// shared constants and types for the pulse steered binary cell
package cell_pkg;

    // system clock and the fastest trigger rate the gates settle at
    localparam int CLK_KHZ = 40000;
    localparam int MAX_RATE_KHZ = 150;
    // least spacing between trigger edges, rounded up to whole cycles
    localparam int MIN_GAP_CYC = (CLK_KHZ + MAX_RATE_KHZ - 1) / MAX_RATE_KHZ;
    localparam int GAP_W = 9;
    localparam logic [GAP_W-1:0] GAP_LIMIT = GAP_W'(MIN_GAP_CYC - 1);

    // wiring choices of the cell
    typedef enum logic [2:0] {
        toggle_mode,
        force_pair_mode,
        steered_pair_mode,
        toggle_force_mode,
        steered_all_mode
    } cell_mode_e;
    localparam logic [2:0] MODE_MAX = 3'h4;
    localparam cell_mode_e MODE_RESET = toggle_mode;

    // pulse pins, index into the synchronised rise vector
    localparam int N_PINS = 5;
    localparam int PIN_TOGGLE = 0;
    localparam int PIN_J = 1;
    localparam int PIN_K = 2;
    localparam int PIN_SET = 3;
    localparam int PIN_CLR = 4;

    // steering gates: main pair takes toggle or j/k, aux pair set/clear
    localparam int N_GATES = 4;
    localparam int GATE_SET_MAIN = 0;
    localparam int GATE_SET_AUX = 1;
    localparam int GATE_CLR_MAIN = 2;
    localparam int GATE_CLR_AUX = 3;

    // register map, byte addresses on the bus
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] CTRL_ADDR = 8'h00;
    localparam logic [ADDR_W-1:0] STATUS_ADDR = 8'h04;
    localparam logic [ADDR_W-1:0] FLIPS_ADDR = 8'h08;

    // field positions
    localparam int CTRL_MODE_LSB = 0;
    localparam int STAT_VAL = 0;
    localparam int STAT_VAL_N = 1;
    localparam int STAT_PRIMED_LSB = 2;
    localparam int STAT_OVERRUN = 6;

    // bus encodings
    localparam int HTRANS_ACTIVE_BIT = 1;
    localparam logic HRESP_OKAY = 1'h0;

endpackage

/* rise_sync.sv */
// two-flop synchroniser with rising edge detection per pin
`timescale 1ns/1ps
module rise_sync #(
    parameter int WIDTH = 5
) (
    input wire logic clock_in,
    input wire logic sys_rst_in,
    input wire logic [WIDTH-1:0] pins_in,
    output logic [WIDTH-1:0] rise_out,
    output logic [WIDTH-1:0] level_out
);

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] sync;
        logic [WIDTH-1:0] prev;
        logic [WIDTH-1:0] rise;
    } sync_state_s;

    sync_state_s state_reg;
    sync_state_s state_next;

    // elaboration check on the width
    if (WIDTH < 1) begin : g_bad_width
        $error("rise_sync: WIDTH must be at least 1");
    end

    // meta feeds only sync; edges come from sync against prev
    // falling edges never reach rise
    always_comb begin
        state_next = state_reg;
        state_next.meta = pins_in;
        state_next.sync = state_reg.meta;
        state_next.prev = state_reg.sync;
        state_next.rise = state_reg.sync & ~state_reg.prev;
    end

    // stages reset high so a pin already high at release is no edge
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            state_reg.meta <= '1;
            state_reg.sync <= '1;
            state_reg.prev <= '1;
            state_reg.rise <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign rise_out = state_reg.rise;
    assign level_out = state_reg.sync;

    default clocking cb @(posedge clock_in); endclocking
    default disable iff (sys_rst_in);

    // one pulse per edge, never two in a row
    property p_rise_single;
        |rise_out |=> ((rise_out & $past(rise_out)) == '0);
    endproperty
    a_rise_single: assert property (p_rise_single) else $error("rise pulse repeated");

    // a falling level never produces a rise
    property p_fall_silent;
        |(~state_reg.sync & state_reg.prev) |=> ((rise_out & ~$past(state_reg.sync)) == '0);
    endproperty
    a_fall_silent: assert property (p_fall_silent) else $error("rise on falling edge");

endmodule

/* pulse_steered_binary_cell.sv */
// one-bit pulse steered binary cell with ahb-lite registers
//
// Local design decisions: register access over AHB-Lite and the address map.
`timescale 1ns/1ps
module pulse_steered_binary_cell #(
    parameter int FLIP_W = 16
) (
    input wire logic clock_in,
    input wire logic sys_rst_in,
    input wire logic pulse_toggle_in,
    input wire logic pulse_j_in,
    input wire logic pulse_k_in,
    input wire logic pulse_set_in,
    input wire logic pulse_clr_in,
    output logic cell_out,
    output logic cell_n_out,
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic hreadyout_out,
    output logic hresp_out,
    output logic [31:0] hrdata_out
);

    // elaboration check: counter must fit a bus word
    if (FLIP_W < 1 || FLIP_W > 32) begin : g_bad_flip_w
        $error("pulse_steered_binary_cell: FLIP_W must be 1 to 32");
    end

    typedef struct packed {
        cell_pkg::cell_mode_e mode;
        logic val;
        logic val_n;
        logic [FLIP_W-1:0] flips;
        logic [cell_pkg::GAP_W-1:0] gap;
        logic overrun;
        logic wr_pend;
        logic [cell_pkg::ADDR_W-1:0] wr_addr;
        logic [31:0] rdata;
    } cell_state_s;

    cell_state_s state_reg;
    cell_state_s state_next;

    logic [cell_pkg::N_PINS-1:0] pins;
    logic [cell_pkg::N_PINS-1:0] rise;
    logic [cell_pkg::N_GATES-1:0] primed_now;
    logic trig_set_main;
    logic trig_clr_main;
    logic set_hit;
    logic clr_hit;
    logic addr_take;

    // which steering gates the current wiring primes for a given state
    function automatic logic [cell_pkg::N_GATES-1:0] primed_gates(
        input cell_pkg::cell_mode_e mode,
        input logic val
    );
        logic [cell_pkg::N_GATES-1:0] g;
        g = '0;
        case (mode)
            cell_pkg::toggle_mode: begin
                g[cell_pkg::GATE_SET_MAIN] = ~val;
                g[cell_pkg::GATE_CLR_MAIN] = val;
                g[cell_pkg::GATE_SET_AUX] = 1'b0;
                g[cell_pkg::GATE_CLR_AUX] = 1'b0;
            end
            cell_pkg::force_pair_mode: begin
                g[cell_pkg::GATE_SET_AUX] = 1'b1;
                g[cell_pkg::GATE_CLR_AUX] = 1'b1;
            end
            cell_pkg::steered_pair_mode: begin
                g[cell_pkg::GATE_SET_MAIN] = ~val;
                g[cell_pkg::GATE_CLR_MAIN] = val;
            end
            cell_pkg::toggle_force_mode: begin
                g[cell_pkg::GATE_SET_MAIN] = ~val;
                g[cell_pkg::GATE_CLR_MAIN] = val;
                g[cell_pkg::GATE_SET_AUX] = 1'b1;
                g[cell_pkg::GATE_CLR_AUX] = 1'b1;
            end
            cell_pkg::steered_all_mode: begin
                g[cell_pkg::GATE_SET_MAIN] = ~val;
                g[cell_pkg::GATE_CLR_MAIN] = val;
                g[cell_pkg::GATE_SET_AUX] = ~val;
                g[cell_pkg::GATE_CLR_AUX] = val;
            end
            default: begin
                g = '0;
            end
        endcase
        return g;
    endfunction

    // mode codes beyond the last wiring are refused
    function automatic logic mode_ok(input logic [2:0] code);
        return code <= cell_pkg::MODE_MAX;
    endfunction

    // gather pins in index order for the synchroniser
    always_comb begin
        pins = '0;
        pins[cell_pkg::PIN_TOGGLE] = pulse_toggle_in;
        pins[cell_pkg::PIN_J] = pulse_j_in;
        pins[cell_pkg::PIN_K] = pulse_k_in;
        pins[cell_pkg::PIN_SET] = pulse_set_in;
        pins[cell_pkg::PIN_CLR] = pulse_clr_in;
    end

    rise_sync #(
        .WIDTH(cell_pkg::N_PINS)
    ) u_rise_sync (
        .clock_in(clock_in),
        .sys_rst_in(sys_rst_in),
        .pins_in(pins),
        .rise_out(rise),
        .level_out()
    );

    // main gates share the toggle line, as the t wiring ties them
    // toggle drives both main gates
    assign trig_set_main = rise[cell_pkg::PIN_TOGGLE] | rise[cell_pkg::PIN_J];
    assign trig_clr_main = rise[cell_pkg::PIN_TOGGLE] | rise[cell_pkg::PIN_K];
    assign primed_now = primed_gates(state_reg.mode, state_reg.val);

    // pulse acts via primed gate on on-side
    // set side acts only while zero
    assign set_hit = ~state_reg.val &
        ((primed_now[cell_pkg::GATE_SET_MAIN] & trig_set_main) |
         (primed_now[cell_pkg::GATE_SET_AUX] & rise[cell_pkg::PIN_SET]));
    // clear side acts only while one
    assign clr_hit = state_reg.val &
        ((primed_now[cell_pkg::GATE_CLR_MAIN] & trig_clr_main) |
         (primed_now[cell_pkg::GATE_CLR_AUX] & rise[cell_pkg::PIN_CLR]));

    // address phase is taken only on an active transfer with ready high
    assign addr_take = hsel_in & htrans_in[cell_pkg::HTRANS_ACTIVE_BIT] & hready_in;

    // next state: bus writes first so hardware events override clears
    always_comb begin
        state_next = state_reg;
        state_next.wr_pend = addr_take & hwrite_in;
        state_next.wr_addr = haddr_in[cell_pkg::ADDR_W-1:0];
        // data phase of a write lands here
        if (state_reg.wr_pend) begin
            case (state_reg.wr_addr)
                cell_pkg::CTRL_ADDR: begin
                    if (mode_ok(hwdata_in[cell_pkg::CTRL_MODE_LSB +: 3])) begin
                        state_next.mode = cell_pkg::cell_mode_e'(hwdata_in[cell_pkg::CTRL_MODE_LSB +: 3]);
                    end
                end
                cell_pkg::STATUS_ADDR: begin
                    if (hwdata_in[cell_pkg::STAT_OVERRUN]) begin
                        state_next.overrun = 1'b0;
                    end
                end
                cell_pkg::FLIPS_ADDR: begin
                    state_next.flips = '0;
                end
                default: begin
                    state_next.flips = state_next.flips;
                end
            endcase
        end
        // stored bit follows one cycle later
        // set and clear cannot both hit: state picks one
        if (set_hit) begin
            state_next.val = 1'b1;
        end else if (clr_hit) begin
            state_next.val = 1'b0;
        end
        // complement kept in its own flop
        state_next.val_n = ~state_next.val;
        // flip count wins over a clear in the same cycle
        if (set_hit | clr_hit) begin
            state_next.flips = state_next.flips + FLIP_W'(1);
        end
        // edges closer than the gate settle time are flagged
        if (|rise) begin
            state_next.gap = '0;
            if (state_reg.gap < cell_pkg::GAP_LIMIT) begin
                state_next.overrun = 1'b1;
            end
        end else if (state_reg.gap != cell_pkg::GAP_LIMIT) begin
            state_next.gap = state_reg.gap + cell_pkg::GAP_W'(1);
        end
        // read data is prepared in the address phase; unmapped reads zero
        if (addr_take & ~hwrite_in) begin
            state_next.rdata = '0;
            case (haddr_in[cell_pkg::ADDR_W-1:0])
                cell_pkg::CTRL_ADDR: begin
                    state_next.rdata[cell_pkg::CTRL_MODE_LSB +: 3] = state_reg.mode;
                end
                cell_pkg::STATUS_ADDR: begin
                    state_next.rdata[cell_pkg::STAT_VAL] = state_reg.val;
                    state_next.rdata[cell_pkg::STAT_VAL_N] = state_reg.val_n;
                    state_next.rdata[cell_pkg::STAT_PRIMED_LSB +: cell_pkg::N_GATES] = primed_now;
                    state_next.rdata[cell_pkg::STAT_OVERRUN] = state_reg.overrun;
                end
                cell_pkg::FLIPS_ADDR: begin
                    state_next.rdata[FLIP_W-1:0] = state_reg.flips;
                end
                default: begin
                    state_next.rdata = '0;
                end
            endcase
        end
    end

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            state_reg.mode <= cell_pkg::MODE_RESET;
            state_reg.val <= 1'b0;
            state_reg.val_n <= 1'b1;
            state_reg.flips <= '0;
            state_reg.gap <= cell_pkg::GAP_LIMIT;
            state_reg.overrun <= 1'b0;
            state_reg.wr_pend <= 1'b0;
            state_reg.wr_addr <= '0;
            state_reg.rdata <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    // zero wait states, always okay: the slave never stalls
    assign hreadyout_out = 1'b1;
    assign hresp_out = cell_pkg::HRESP_OKAY;
    assign hrdata_out = state_reg.rdata;
    assign cell_out = state_reg.val;
    assign cell_n_out = state_reg.val_n;

    default clocking cb @(posedge clock_in); endclocking
    default disable iff (sys_rst_in);

    logic [cell_pkg::N_PINS-1:0] other_set;
    assign other_set = rise & ~(cell_pkg::N_PINS'(1) << cell_pkg::PIN_SET);

    sequence s_toggle_only;
        state_reg.mode == cell_pkg::toggle_mode && rise[cell_pkg::PIN_TOGGLE];
    endsequence

    sequence s_flipped;
        cell_out != $past(cell_out);
    endsequence

    property p_release_zero;
        $fell(sys_rst_in) |-> !cell_out && cell_n_out;
    endproperty
    a_release_zero: assert property (p_release_zero) else $error("cell not zero after reset");

    property p_complement;
        cell_out != cell_n_out;
    endproperty
    a_complement: assert property (p_complement) else $error("outputs not complementary");

    property p_toggle_flip;
        s_toggle_only |=> s_flipped;
    endproperty
    a_toggle_flip: assert property (p_toggle_flip) else $error("toggle pulse did not flip");

    property p_toggle_steer;
        state_reg.mode == cell_pkg::toggle_mode |->
            primed_now[cell_pkg::GATE_SET_MAIN] == !cell_out &&
            primed_now[cell_pkg::GATE_CLR_MAIN] == cell_out;
    endproperty
    a_toggle_steer: assert property (p_toggle_steer) else $error("toggle gates mis-steered");

    property p_toggle_aux_dead;
        state_reg.mode == cell_pkg::toggle_mode && !rise[cell_pkg::PIN_TOGGLE] && !rise[cell_pkg::PIN_J] &&
            !rise[cell_pkg::PIN_K] |=> $stable(cell_out);
    endproperty
    a_toggle_aux_dead: assert property (p_toggle_aux_dead) else $error("toggle mode disturbed");

    property p_force_set;
        state_reg.mode == cell_pkg::force_pair_mode && rise[cell_pkg::PIN_SET] && !cell_out |=> cell_out;
    endproperty
    a_force_set: assert property (p_force_set) else $error("set pulse missed");

    property p_force_clr;
        state_reg.mode == cell_pkg::force_pair_mode && rise[cell_pkg::PIN_CLR] && cell_out |=> !cell_out;
    endproperty
    a_force_clr: assert property (p_force_clr) else $error("clear pulse missed");

    property p_force_hold;
        state_reg.mode == cell_pkg::force_pair_mode && cell_out && !rise[cell_pkg::PIN_CLR] |=> cell_out;
    endproperty
    a_force_hold: assert property (p_force_hold) else $error("redundant set changed state");

    property p_steered_both;
        state_reg.mode == cell_pkg::steered_pair_mode && rise[cell_pkg::PIN_J] && rise[cell_pkg::PIN_K]
            |=> s_flipped ##1 $stable(cell_out);
    endproperty
    a_steered_both: assert property (p_steered_both) else $error("coincident pair not single flip");

    property p_tf_set;
        state_reg.mode == cell_pkg::toggle_force_mode && rise[cell_pkg::PIN_SET] && !cell_out |=> cell_out;
    endproperty
    a_tf_set: assert property (p_tf_set) else $error("toggle force set missed");

    property p_all_set_redundant;
        state_reg.mode == cell_pkg::steered_all_mode && cell_out && other_set == '0 |=> cell_out;
    endproperty
    a_all_set_redundant: assert property (p_all_set_redundant) else $error("steered all moved");

    property p_no_hit_no_change;
        !(set_hit || clr_hit) |=> $stable(cell_out) ##1 1'b1;
    endproperty
    a_no_hit_no_change: assert property (p_no_hit_no_change) else $error("change without primed gate");

    property p_tf_clr;
        state_reg.mode == cell_pkg::toggle_force_mode && rise[cell_pkg::PIN_CLR] && cell_out |=> !cell_out;
    endproperty
    a_tf_clr: assert property (p_tf_clr) else $error("toggle force clear missed");

    property p_edge_next;
        (set_hit || clr_hit) |=> s_flipped;
    endproperty
    a_edge_next: assert property (p_edge_next) else $error("update not in next cycle");

endmodule

/* pulse_driver.sv */
// partner model: driving pulse logic feeding the cell's trigger pins
`timescale 1ns/1ps
module pulse_driver (
    input wire logic clock_in,
    output logic [4:0] pins_out
);
    // idle lines sit low so that every pulse starts with a clean rise
    initial begin
        pins_out = 5'h00;
    end

    // one positive pulse on the masked pins, four cycles wide
    // spacing after pulse
    // coincident set/clear only when the caller asks
    task automatic fire(input logic [4:0] mask, input int gap);
        @(posedge clock_in);
        pins_out <= mask;
        repeat (4) @(posedge clock_in);
        pins_out <= 5'h00;
        // the caller picks a short gap only to provoke the overrun flag
        repeat (gap) @(posedge clock_in);
    endtask
endmodule

/* testbench.sv */
// self-checking bench for the pulse steered binary cell
`timescale 1ns/1ps
module testbench;
    logic clock_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [4:0] pins;
    logic hreadyout_out;
    logic hresp_out;
    logic [31:0] hrdata_out;
    logic cell_out;
    logic cell_n_out;
    int num_errors = 0;
    int tests_run = 0;
    localparam logic [4:0] T = 5'h01;
    localparam logic [4:0] J = 5'h02;
    localparam logic [4:0] K = 5'h04;
    localparam logic [4:0] S = 5'h08;
    localparam logic [4:0] C = 5'h10;
    localparam logic [31:0] A_CTRL = {24'h0, cell_pkg::CTRL_ADDR};
    localparam logic [31:0] A_STAT = {24'h0, cell_pkg::STATUS_ADDR};
    localparam logic [31:0] A_FLIP = {24'h0, cell_pkg::FLIPS_ADDR};

    // 40 mhz system clock
    always #12.5 clock_in = ~clock_in;

    pulse_driver drv (
        .clock_in(clock_in),
        .pins_out(pins)
    );

    pulse_steered_binary_cell DUT (
        .clock_in(clock_in),
        .sys_rst_in(sys_rst_in),
        .pulse_toggle_in(pins[cell_pkg::PIN_TOGGLE]),
        .pulse_j_in(pins[cell_pkg::PIN_J]),
        .pulse_k_in(pins[cell_pkg::PIN_K]),
        .pulse_set_in(pins[cell_pkg::PIN_SET]),
        .pulse_clr_in(pins[cell_pkg::PIN_CLR]),
        .cell_out(cell_out),
        .cell_n_out(cell_n_out),
        .hsel_in(hsel),
        .haddr_in(haddr),
        .htrans_in(htrans),
        .hwrite_in(hwrite),
        .hsize_in(hsize),
        .hwdata_in(hwdata),
        .hready_in(hreadyout_out),
        .hreadyout_out(hreadyout_out),
        .hresp_out(hresp_out),
        .hrdata_out(hrdata_out)
    );

    task automatic end_of_test();
        $display("checks %0d, mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
            num_errors++;
        end
    endtask

    // hready sampled at the edge itself, before that edge's updates land
    task automatic wait_ready();
        do @(posedge clock_in); while (hreadyout_out !== 1'b1);
    endtask

    // one single word transfer: address phase, then data phase
    task automatic ahb(input logic wr, input logic [31:0] addr, input logic [31:0] wdata, output logic [31:0] rdata);
        @(posedge clock_in);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= addr;
        hwrite <= wr;
        hsize <= 3'h2;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wdata;
        wait_ready();
        rdata = hrdata_out;
        check("hready", 32'h1, {31'h0, hreadyout_out});
        check("hresp", {31'h0, cell_pkg::HRESP_OKAY}, {31'h0, hresp_out});
    endtask

    task automatic wr(input logic [31:0] addr, input logic [31:0] data);
        logic [31:0] dummy;
        ahb(1'b1, addr, data, dummy);
    endtask

    task automatic rd(input string name, input logic [31:0] addr, input logic [31:0] exp);
        logic [31:0] got;
        ahb(1'b0, addr, 32'h0, got);
        check(name, exp, got);
    endtask

    task automatic chk_cell(input logic exp);
        check("cell_out", {31'h0, exp}, {31'h0, cell_out});
        check("cell_n_out", {31'h0, ~exp}, {31'h0, cell_n_out});
    endtask

    // pulse, then confirm the stored bit once the pins are quiet again
    task automatic pulse(input logic [4:0] mask, input logic exp);
        drv.fire(mask, 300);
        chk_cell(exp);
    endtask

    // hang guard, well past the expected ten thousand cycles
    initial begin
        repeat (60000) @(posedge clock_in);
        num_errors++;
        end_of_test();
    end

    initial begin
        logic [31:0] st;
        repeat (20) @(posedge clock_in);
        sys_rst_in <= 1'b0;
        repeat (4) @(posedge clock_in);
        chk_cell(1'b0);
        rd("ctrl", A_CTRL, 32'h0);
        rd("status", A_STAT, 32'h6);
        // unmapped place reads zero and ignores writes
        wr(32'h0c, 32'hffff_ffff);
        rd("unmapped", 32'h0c, 32'h0);
        // toggle mode
        wr(A_FLIP, 32'h1);
        pulse(T, 1'b1);
        pulse(T, 1'b0);
        pulse(T, 1'b1);
        pulse(S, 1'b1);
        pulse(C, 1'b1);
        rd("flips", A_FLIP, 32'h3);
        rd("status", A_STAT, 32'h11);
        // force pair mode; code 5 must be refused
        wr(A_CTRL, 32'(cell_pkg::force_pair_mode));
        wr(A_CTRL, 32'h5);
        rd("ctrl", A_CTRL, 32'(cell_pkg::force_pair_mode));
        rd("status", A_STAT, 32'h29);
        pulse(T, 1'b1);
        pulse(C, 1'b0);
        pulse(C, 1'b0);
        pulse(S, 1'b1);
        pulse(S, 1'b1);
        pulse(J | K, 1'b1);
        // coincident set and clear: only the complement relation is relied on
        drv.fire(S | C, 300);
        check("complement", {31'h0, ~cell_out}, {31'h0, cell_n_out});
        pulse(C, 1'b0);
        // steered pair mode, the choice for coincident pulses
        // coincidence handled by steered pair
        wr(A_CTRL, 32'(cell_pkg::steered_pair_mode));
        pulse(K, 1'b0);
        pulse(J, 1'b1);
        pulse(J, 1'b1);
        pulse(J | K, 1'b0);
        pulse(J | K, 1'b1);
        pulse(S | C, 1'b1);
        // toggle with set and clear; first flip also timed from the pin edge
        wr(A_CTRL, 32'(cell_pkg::toggle_force_mode));
        fork
            drv.fire(T, 300);
            begin
                repeat (3) @(posedge clock_in);
                chk_cell(1'b1);
                repeat (3) @(posedge clock_in);
                chk_cell(1'b0);
            end
        join
        pulse(S, 1'b1);
        pulse(S, 1'b1);
        pulse(C, 1'b0);
        pulse(T, 1'b1);
        // steered all: set and clear gates follow the outputs
        wr(A_CTRL, 32'(cell_pkg::steered_all_mode));
        pulse(C, 1'b0);
        pulse(S, 1'b1);
        rd("status", A_STAT, 32'h31);
        pulse(S, 1'b1);
        pulse(T, 1'b0);
        // edges too close set the sticky flag but still act
        wr(A_CTRL, 32'(cell_pkg::toggle_mode));
        rd("status", A_STAT, 32'h06);
        drv.fire(T, 40);
        pulse(T, 1'b0);
        ahb(1'b0, A_STAT, 32'h0, st);
        check("overrun", 32'h40, st & 32'h40);
        wr(A_STAT, 32'h40);
        rd("status", A_STAT, 32'h06);
        // any write to the flip count address clears it, whatever the data
        wr(A_FLIP, 32'h0);
        rd("flips", A_FLIP, 32'h0);
        // second reset in mid-run
        pulse(T, 1'b1);
        wr(A_CTRL, 32'(cell_pkg::steered_pair_mode));
        @(posedge clock_in);
        sys_rst_in <= 1'b1;
        repeat (2) @(posedge clock_in);
        sys_rst_in <= 1'b0;
        @(posedge clock_in);
        chk_cell(1'b0);
        rd("ctrl", A_CTRL, 32'h0);
        end_of_test();
    end
endmodule
